// *** overfill_cfg.svh ***
// timing counts and channel counts for the overfill interlock controller
`ifndef OVERFILL_CFG_SVH
`define OVERFILL_CFG_SVH
`define CLK_HZ            20000000
`define CH_TWO_WIRE       8
`define CH_FIVE_WIRE      12
`define CH_MAX            12
// self-check cycle, well below the 450 ms controller limit
`define CHECK_MS          1
`define CHECK_CYCLES      (`CLK_HZ / 1000 * `CHECK_MS)
`define CTRL_LIMIT_MS     450
`define SYS_LIMIT_MS      700
`define CTRL_LIMIT_CYCLES (`CLK_HZ / 1000 * `CTRL_LIMIT_MS)
// bond resistance limit in ohms, measured code compared directly
`define BOND_MAX_OHM      10000
`define OHM_W             16
`endif

// *** overfill_pkg.sv ***
// types shared by the overfill interlock controller
package overfill_pkg;
  typedef enum logic [1:0] {SCHEME_NONE, SCHEME_TWO, SCHEME_FIVE} scheme_e;
  // per-channel front-end view of the plug
  typedef struct packed {
    logic [11:0] present;
    logic [11:0] wet;
    logic [11:0] fault;
  } sense_s;
  typedef struct packed {
    logic        red;
    logic        green;
    logic        bond_ok;
    logic [11:0] wet_id;
  } lamps_s;
endpackage

// *** check_tick.sv ***
// self-check cycle divider
`timescale 1ns/10ps
`include "overfill_cfg.svh"
module check_tick (
  input  wire logic clk,
  input  wire logic reset,
  output logic      tick
);
  logic [31:0] count;
  logic [31:0] next_count;
  logic        next_tick;

  // count down one self-check period, pulse at the end
  always_comb begin
    next_tick  = 1'b0;
    next_count = count - 32'h1;
    if (count == 32'h0) begin
      next_count = 32'(`CHECK_CYCLES - 1);
      next_tick  = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      count <= 32'(`CHECK_CYCLES - 1);
      tick  <= 1'b0;
    end else begin
      count <= next_count;
      tick  <= next_tick;
    end
  end
endmodule

// *** scheme_detect.sv ***
// two-wire / five-wire scheme recognition
`timescale 1ns/10ps
module scheme_detect (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  tick,
  input  wire logic                  two_seen,
  input  wire logic                  five_seen,
  output overfill_pkg::scheme_e      scheme,
  output logic                       clash
);
  overfill_pkg::scheme_e next_scheme;
  logic                  next_clash;

  // re-decided each self-check; both signatures at once is a fault
  always_comb begin
    next_scheme = scheme;
    next_clash  = clash;
    if (tick) begin
      next_clash = two_seen & five_seen;
      if (two_seen && !five_seen) begin
        next_scheme = overfill_pkg::SCHEME_TWO;
      end else if (five_seen && !two_seen) begin
        next_scheme = overfill_pkg::SCHEME_FIVE;
      end else begin
        next_scheme = overfill_pkg::SCHEME_NONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      scheme <= overfill_pkg::SCHEME_NONE;
      clash  <= 1'b0;
    end else begin
      scheme <= next_scheme;
      clash  <= next_clash;
    end
  end
endmodule

// *** overfill_interlock_controller.sv ***
// overfill interlock controller top: sensor evaluation, bond watch, output
`timescale 1ns/10ps
`include "overfill_cfg.svh"
module overfill_interlock_controller (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire overfill_pkg::sense_s    sense,
  input  wire logic                    two_seen,
  input  wire logic                    five_seen,
  input  wire logic                    bond_fault,
  input  wire logic [`OHM_W-1:0]       bond_ohm,
  input  wire logic                    self_fault,
  output logic                         permit,
  output overfill_pkg::lamps_s         lamps,
  output overfill_pkg::scheme_e        scheme_seen
);
  // ----------------------------------------------------------------
  // self-check timing and scheme
  // ----------------------------------------------------------------
  logic                  tick;
  logic                  clash;
  overfill_pkg::scheme_e scheme;

  check_tick u_tick (
    .clk   (clk),
    .reset (reset),
    .tick  (tick)
  );

  scheme_detect u_scheme (
    .clk       (clk),
    .reset     (reset),
    .tick      (tick),
    .two_seen  (two_seen),
    .five_seen (five_seen),
    .scheme    (scheme),
    .clash     (clash)
  );

  // channel mask for the detected scheme, used by both evaluation and lamps
  function automatic logic [11:0] active_mask(input overfill_pkg::scheme_e s);
    logic [11:0] m;
    m = 12'h000;
    case (s)
      overfill_pkg::SCHEME_TWO:  m = 12'h0FF;
      overfill_pkg::SCHEME_FIVE: m = 12'hFFF;
      default:                   m = 12'h000;
    endcase
    return m;
  endfunction

  // ----------------------------------------------------------------
  // per-channel evaluation
  // ----------------------------------------------------------------
  logic [11:0] mask;
  logic [11:0] chan_bad;
  logic [11:0] chan_wet;
  assign mask = active_mask(scheme);

  // two-wire always watches all eight; a missing channel means no dummy
  genvar g;
  generate
    for (g = 0; g < `CH_MAX; g = g + 1) begin : g_ch
      assign chan_wet[g] = mask[g] & sense.wet[g];
      assign chan_bad[g] = mask[g] & (sense.wet[g] | sense.fault[g]
                                      | ~sense.present[g]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // trip decision and output
  // ----------------------------------------------------------------
  logic        bond_bad;
  logic        any_bad;
  logic        dry_ok;
  logic        next_permit;
  logic [11:0] next_wet_id;
  logic        next_bond_ok;

  // bond watched every cycle, not only at self-check
  assign bond_bad = bond_fault | (bond_ohm > `OHM_W'(`BOND_MAX_OHM));
  assign any_bad  = (|chan_bad) | bond_bad | self_fault | clash
                    | (scheme == overfill_pkg::SCHEME_NONE);

  // dry thermistors simply stay bad until warm; no timeout is imposed
  logic dry_stable;
  logic next_dry_stable;

  // a trip acts on the very next edge; permission is only granted at a
  // self-check after a whole clean cycle, so a flicker cannot enable loading
  always_comb begin
    dry_ok          = ~any_bad;
    next_dry_stable = dry_stable;
    next_permit     = permit;
    if (!dry_ok) begin
      next_dry_stable = 1'b0;
      next_permit     = 1'b0;
    end else if (tick) begin
      next_permit     = dry_stable;
      next_dry_stable = 1'b1;
    end
    next_wet_id  = chan_wet;
    next_bond_ok = ~bond_bad;
  end

  // reset and power-up clear to non-permissive; contact is normally open
  always_ff @(posedge clk) begin
    if (reset) begin
      permit     <= 1'b0;
      dry_stable <= 1'b0;
      // red lit from reset on, so the lamps never disagree with the output
      lamps      <= '{red: 1'b1, green: 1'b0, bond_ok: 1'b0, wet_id: 12'h000};
      scheme_seen <= overfill_pkg::SCHEME_NONE;
    end else begin
      dry_stable  <= next_dry_stable;
      permit      <= next_permit;
      lamps.red   <= ~next_permit;
      lamps.green <= next_permit;
      lamps.bond_ok <= next_bond_ok;
      lamps.wet_id  <= next_wet_id;
      scheme_seen <= scheme;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_trip_wet: assert property (|chan_wet |=> !permit)
    else $error("wet channel did not drop permit");
  chk_bond_trip: assert property (bond_bad |=> !permit && !lamps.bond_ok)
    else $error("bond fault did not drop permit");
  chk_permit_clean: assert property ($rose(permit) |-> $past(tick) && !$past(any_bad))
    else $error("permit rose without clean self-check");
  chk_lamp_pair: assert property (lamps.green == permit && lamps.red == !permit)
    else $error("lamps disagree with output");
  chk_self_fault: assert property (self_fault |=> !permit)
    else $error("controller fault did not drop permit");
  chk_no_scheme: assert property (scheme == overfill_pkg::SCHEME_NONE |=> !permit)
    else $error("permit without detected scheme");
  chk_two_range: assert property (scheme == overfill_pkg::SCHEME_TWO |-> mask == 12'h0FF)
    else $error("two-wire mask wrong");
  chk_wet_id: assert property (sense.wet[0] && mask[0] |=> lamps.wet_id[0])
    else $error("wet channel not indicated");
  chk_reset_out: assert property (@(posedge clk) $fell(reset) |-> !permit)
    else $error("permit set out of reset");

  cov_permit: cover property ($rose(permit));
  cov_trip:   cover property (permit ##1 !permit);
  cov_five:   cover property (scheme == overfill_pkg::SCHEME_FIVE && permit);
endmodule

// *** vehicle_model.sv ***
// vehicle side model: two-wire sensors, dummy sensors and the bond
`timescale 1ns/10ps
module vehicle_model #(
  parameter int WARM_CYC = 40
) (
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic [3:0]      n_comp,
  input  wire logic [11:0]     wet_mask,
  input  wire logic            bond_open,
  input  wire logic [15:0]     ohm,
  output overfill_pkg::sense_s sense,
  output logic                 two_seen,
  output logic                 five_seen,
  output logic                 bond_fault,
  output logic [15:0]          bond_ohm
);
  logic [7:0]  warm;
  logic [11:0] junk;
  // ----
  // warm-up count and churn on unwired pins
  // ----
  // reset stands for plugging in; junk toggles so stale levels never look valid
  always_ff @(posedge clk) begin
    junk <= reset ? 12'hA5A : ~junk;
    if (reset) begin
      warm <= 8'h00;
    end else if (warm < 8'(WARM_CYC)) begin
      warm <= warm + 8'h01;
    end
  end
  // channel levels seen at the socket
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      if (i < 8) begin
        sense.present[i] = 1'b1; // fitted sensor or dummy
        sense.fault[i]   = 1'b0;
        // thermistor reads wet until warm dummy stays dry
        sense.wet[i] = (4'(i) < n_comp) && (wet_mask[i] || warm < 8'(WARM_CYC));
      end else begin
        sense.present[i] = junk[i];
        sense.fault[i]   = ~junk[i];
        sense.wet[i]     = junk[i];
      end
    end
  end
  assign two_seen   = 1'b1;
  assign five_seen  = 1'b0;
  assign bond_fault = bond_open;
  assign bond_ohm   = ohm;
endmodule

// *** overfill_interlock_controller_bench.sv ***
// self-checking bench for the overfill interlock controller
`timescale 1ns/10ps
`include "overfill_cfg.svh"
module overfill_interlock_controller_bench;
  logic                  clk = 1'b0;
  logic                  reset = 1'b1;
  logic                  self_fault = 1'b0;
  logic [3:0]            n_comp = 4'h5;
  logic [11:0]           wet_mask = 12'h000;
  logic                  bond_open = 1'b0;
  logic [15:0]           ohm = 16'h03E8;
  overfill_pkg::sense_s  sense;
  logic                  two_seen;
  logic                  five_seen;
  logic                  bond_fault;
  logic [15:0]           bond_ohm;
  logic                  permit;
  overfill_pkg::lamps_s  lamps;
  overfill_pkg::scheme_e scheme_seen;
  int                    n_errors = 0;
  int                    num_checks = 0;
  int                    cyc = 0;
  // ----
  // clock, hang limit, parts
  // ----
  always #25 clk = ~clk;
  // the tick period is fixed in the design, so the limit covers four ticks
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4 * `CHECK_CYCLES) begin
      n_errors++;
      end_of_test();
    end
  end
  vehicle_model vehicle_model_inst (.clk(clk), .reset(reset), .n_comp(n_comp),
    .wet_mask(wet_mask), .bond_open(bond_open), .ohm(ohm), .sense(sense),
    .two_seen(two_seen), .five_seen(five_seen), .bond_fault(bond_fault),
    .bond_ohm(bond_ohm));
  overfill_interlock_controller overfill_interlock_controller_inst (.clk(clk),
    .reset(reset), .sense(sense), .two_seen(two_seen), .five_seen(five_seen),
    .bond_fault(bond_fault), .bond_ohm(bond_ohm), .self_fault(self_fault),
    .permit(permit), .lamps(lamps), .scheme_seen(scheme_seen));
  // ----
  // tasks
  // ----
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // inputs move 2 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    step(16);
    check_bit(permit, 1'b0);
    check_val(16'(scheme_seen), 16'(overfill_pkg::SCHEME_NONE));
    reset = 1'b0;
    step(1);
    check_bit(lamps.red, 1'b1);
    check_bit(lamps.green, 1'b0);
    // bond limit edge, then an open bond
    ohm = 16'h2710;
    step(2);
    check_bit(lamps.bond_ok, 1'b1);
    ohm = 16'h2711;
    step(2);
    check_bit(lamps.bond_ok, 1'b0);
    ohm = 16'h03E8;
    bond_open = 1'b1;
    step(2);
    check_bit(lamps.bond_ok, 1'b0);
    bond_open = 1'b0;
    step(2);
    check_bit(lamps.bond_ok, 1'b1);
    // clean vehicle with three dummies: permit comes only on a later tick
    while (permit !== 1'b1 && cyc < 3 * `CHECK_CYCLES + 24) begin
      step(1);
    end
    check_bit(permit, 1'b1);
    check_bit(cyc >= 2 * `CHECK_CYCLES, 1'b1);
    check_bit(cyc <= 3 * `CHECK_CYCLES + 20, 1'b1);
    check_val(16'(scheme_seen), 16'(overfill_pkg::SCHEME_TWO));
    step(1);
    check_bit(lamps.green, 1'b1);
    check_bit(lamps.red, 1'b0);
    // pins 8..11 churn meanwhile and must not matter
    for (int i = 0; i < 20; i++) begin
      step(1);
      check_bit(permit, 1'b1);
    end
    // last fitted compartment sensor goes wet; channels 5..7 are dummies
    wet_mask = 12'h010;
    step(1);
    check_bit(permit, 1'b0);
    step(1);
    check_bit(lamps.red, 1'b1);
    check_val(16'(lamps.wet_id), 16'h0010);
    end_of_test();
  end
endmodule
